//--- include/twm_cfg.svh
// Purpose: constants of the two-wire master-receiver controller
// Assumes: 100 MHz sys_clk, AXI4-Lite register access
// Notes:   status codes assume the prescaler field reads as zero
`ifndef TWM_CFG_SVH
`define TWM_CFG_SVH

// ----------------------------------------------------------------
// register map and fields
// ----------------------------------------------------------------
`define TWM_OFF_CTRL   8'h00
`define TWM_OFF_STAT   8'h04
`define TWM_OFF_DATA   8'h08
`define TWM_B_FLAG     7
`define TWM_B_ACK      6
`define TWM_B_STA      5
`define TWM_B_STO      4
`define TWM_B_WC       3
`define TWM_B_EN       2
`define TWM_B_IE       0
`define TWM_STAT_RST   8'hf8
`define TWM_RESP_OKAY  2'b00
`define TWM_RESP_SLV   2'b10

// ----------------------------------------------------------------
// status codes
// ----------------------------------------------------------------
`define TWM_ST_START   8'h08
`define TWM_ST_RSTART  8'h10
`define TWM_ST_WA_ACK  8'h18
`define TWM_ST_WA_NAK  8'h20
`define TWM_ST_WD_ACK  8'h28
`define TWM_ST_WD_NAK  8'h30
`define TWM_ST_LOST    8'h38
`define TWM_ST_RA_ACK  8'h40
`define TWM_ST_RA_NAK  8'h48
`define TWM_ST_RD_ACK  8'h50
`define TWM_ST_RD_NAK  8'h58

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TWM_CLK_NS     10
`define TWM_QTR_NS     2500
`define TWM_QTR_CYC    ((`TWM_QTR_NS + `TWM_CLK_NS - 1) / `TWM_CLK_NS)

`endif

//--- include/twm_pkg.sv
// Purpose: types of the two-wire master-receiver controller
// Assumes: nothing beyond SystemVerilog packages
// Notes:   pin struct carries open-drain out and enable pairs
package twm_pkg;

    typedef enum logic [2:0]
    {
        TWM_IDLE,
        TWM_WAIT_FREE,
        TWM_START,
        TWM_BIT,
        TWM_HOLD,
        TWM_LOST,
        TWM_STOP
    } twm_state_t;

    typedef struct packed
    {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } twm_pins_t;

    typedef struct packed
    {
        logic scl;
        logic sda;
    } twm_line_t;

endpackage : twm_pkg

//--- logic/twm_line_sync.sv
// Purpose: bring the two bus lines into the sys_clk domain
// Assumes: lines are asynchronous to sys_clk
// Notes:   prev is one cycle older than now, for edge finding
`timescale 1ns/1ps
module twm_line_sync (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // raw and synchronised lines
    input  wire twm_pkg::twm_line_t line_in,
    output twm_pkg::twm_line_t     line_now,
    output twm_pkg::twm_line_t     line_prev
);
    import twm_pkg::*;

    logic [1:0] meta;
    logic [1:0] stab;
    logic [1:0] prev;

    genvar i;
    generate
        for (i = 0; i < 2; i++)
        begin : g_sync
            // idle bus is high, so reset to high
            always_ff @(posedge sys_clk)
            begin
                if (sys_rst)
                begin
                    meta[i] <= 1'b1;
                    stab[i] <= 1'b1;
                    prev[i] <= 1'b1;
                end
                else
                begin
                    meta[i] <= line_in[i];
                    stab[i] <= meta[i];
                    prev[i] <= stab[i];
                end
            end
        end
    endgenerate

    assign line_now  = stab;
    assign line_prev = prev;

endmodule : twm_line_sync

//--- logic/twm_master_rx.sv
// Purpose: two-wire bus master controller, receive path, AXI4-Lite registers
// Assumes: 100 MHz sys_clk, synchronous active-high reset
// Notes:   bit timing is four fixed quarters; the slave may stretch the clock
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "twm_cfg.svh"
module twm_master_rx (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // axi4-lite write
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    // axi4-lite read
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // two-wire bus
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output twm_pkg::twm_pins_t pins_out
);
    import twm_pkg::*;

    localparam logic [8:0] QTR_M1 = 9'(`TWM_QTR_CYC - 1);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic       flag, ctl_ack, ctl_sta, ctl_sto, ctl_wc, ctl_en, ctl_ie;
    logic [1:0] prescaler;
    logic [7:0] status_code, data_reg;
    logic       aw_full, w_full;
    logic [7:0] aw_addr;
    logic [7:0] w_byte;
    logic       w_lane;
    twm_state_t state;
    logic [1:0] phase;
    logic [8:0] cnt;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic       tx, addr_byte, rd_dir, ack_rx, ack_sent, owner, busy;
    logic       scl_low, sda_low;
    twm_line_t  line_now, line_prev;

    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == `TWM_OFF_CTRL) || (a == `TWM_OFF_STAT) || (a == `TWM_OFF_DATA);
    endfunction : reg_hit

    // high when the bit slot n pulls data low
    function automatic logic bit_drive(input logic [3:0] n, input logic t,
                                       input logic b7, input logic ak);
        if (n < 4'h8)
            bit_drive = t & ~b7;
        else
            bit_drive = ~t & ak;
    endfunction : bit_drive

    // ----------------------------------------------------------------
    // line synchroniser
    // ----------------------------------------------------------------
    twm_line_sync u_sync (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .line_in   ('{scl: scl_in, sda: sda_in}),
        .line_now  (line_now),
        .line_prev (line_prev)
    );

    assign pins_out.scl_o  = 1'b0;
    assign pins_out.scl_oe = scl_low;
    assign pins_out.sda_o  = 1'b0;
    assign pins_out.sda_oe = sda_low;

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    wire wr_fire = aw_full && w_full && !bvalid;
    wire wr_ctl  = wr_fire && w_lane && (aw_addr == `TWM_OFF_CTRL);
    wire wr_stat = wr_fire && w_lane && (aw_addr == `TWM_OFF_STAT);
    wire wr_dat  = wr_fire && w_lane && (aw_addr == `TWM_OFF_DATA);
    wire [7:0] ctrl_rd = {flag, ctl_ack, ctl_sta, ctl_sto, ctl_wc, ctl_en, 1'b0, ctl_ie};
    wire [7:0] stat_rd = {status_code[7:3], 1'b0, prescaler};
    wire [7:0] rd_mux  = (araddr == `TWM_OFF_CTRL) ? ctrl_rd :
                         (araddr == `TWM_OFF_STAT) ? stat_rd :
                         (araddr == `TWM_OFF_DATA) ? data_reg : 8'h00;

    assign awready = !aw_full;
    assign wready  = !w_full;
    assign arready = !rvalid;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            aw_addr <= 8'h00;
            w_byte  <= 8'h00;
            w_lane  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= `TWM_RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_full <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_full <= 1'b1;
                w_byte <= wdata[7:0];
                w_lane <= wstrb[0];
            end
            if (wr_fire)
            begin
                aw_full <= 1'b0;
                w_full  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= reg_hit(aw_addr) ? `TWM_RESP_OKAY : `TWM_RESP_SLV;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `TWM_RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rdata  <= {24'h00_0000, rd_mux};
            rresp  <= reg_hit(araddr) ? `TWM_RESP_OKAY : `TWM_RESP_SLV;
        end
        else if (rvalid && rready)
            rvalid <= 1'b0;
    end

    // ----------------------------------------------------------------
    // sequencer decode
    // ----------------------------------------------------------------
    wire running  = (state == TWM_START) || (state == TWM_BIT) || (state == TWM_STOP);
    wire step     = running && (cnt == QTR_M1);
    wire start_dn = step && (state == TWM_START) && (phase == 2'd3);
    wire sample   = step && (state == TWM_BIT) && (phase == 2'd1);
    wire byte_dn  = step && (state == TWM_BIT) && (phase == 2'd3) && (bitn == 4'h8);
    wire stop_dn  = step && (state == TWM_STOP) && (phase == 2'd3);
    wire lost_now = sample && !sda_low && !line_now.sda &&
                    ((tx && bitn < 4'h8) || (!tx && bitn == 4'h8));
    wire rx_load  = byte_dn && !tx;
    wire set_flag = start_dn || byte_dn || lost_now;
    wire [7:0] tx_code = !addr_byte ? (ack_rx ? `TWM_ST_WD_ACK : `TWM_ST_WD_NAK) :
                         rd_dir     ? (ack_rx ? `TWM_ST_RA_ACK : `TWM_ST_RA_NAK) :
                                      (ack_rx ? `TWM_ST_WA_ACK : `TWM_ST_WA_NAK);
    wire [7:0] next_code = lost_now ? `TWM_ST_LOST :
                           start_dn ? (owner ? `TWM_ST_RSTART : `TWM_ST_START) :
                           tx       ? tx_code :
                           (ack_sent ? `TWM_ST_RD_ACK : `TWM_ST_RD_NAK);
    wire bus_start = line_now.scl && line_prev.sda && !line_now.sda;
    wire bus_stop  = line_now.scl && !line_prev.sda && line_now.sda;
    wire code_addr = (status_code == `TWM_ST_START) || (status_code == `TWM_ST_RSTART);
    wire code_rx   = (status_code == `TWM_ST_RA_ACK) || (status_code == `TWM_ST_RD_ACK);
    wire code_tx   = (status_code == `TWM_ST_WA_ACK) || (status_code == `TWM_ST_WA_NAK) ||
                     (status_code == `TWM_ST_WD_ACK) || (status_code == `TWM_ST_WD_NAK);

    // ----------------------------------------------------------------
    // control, status and data registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            {flag, ctl_ack, ctl_sta, ctl_sto, ctl_wc, ctl_en, ctl_ie} <= 7'h00;
            prescaler   <= 2'b00;
            status_code <= `TWM_STAT_RST;
            data_reg    <= 8'h00;
        end
        else
        begin
            if (wr_ctl)
            begin
                ctl_ack <= w_byte[`TWM_B_ACK];
                ctl_sta <= w_byte[`TWM_B_STA];
                ctl_en  <= w_byte[`TWM_B_EN];
                ctl_ie  <= w_byte[`TWM_B_IE];
            end
            if (wr_ctl)
                ctl_sto <= w_byte[`TWM_B_STO];
            else if (stop_dn)
                ctl_sto <= 1'b0;
            if (set_flag)
                flag <= 1'b1;
            else if (wr_ctl && w_byte[`TWM_B_FLAG])
                flag <= 1'b0;
            if (wr_dat)
                ctl_wc <= !flag;
            if (wr_stat)
                prescaler <= w_byte[1:0];
            if (set_flag)
                status_code <= next_code;
            if (rx_load)
                data_reg <= shreg;
            else if (wr_dat && flag)
                data_reg <= w_byte;
        end
    end

    // ----------------------------------------------------------------
    // bus activity tracking and quarter timer
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            busy <= 1'b0;
        else if (bus_start)
            busy <= 1'b1;
        else if (bus_stop)
            busy <= 1'b0;
    end

    // phase 1 waits for the released clock to read high: slave stretching
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || !running || step || (phase == 2'd1 && !line_now.scl))
            cnt <= 9'd0;
        else
            cnt <= cnt + 9'd1;
    end

    // ----------------------------------------------------------------
    // bus sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || !ctl_en)
        begin
            state   <= TWM_IDLE;
            {phase, bitn, shreg} <= 14'h0000;
            {tx, addr_byte, rd_dir, ack_rx, ack_sent, owner} <= 6'h00;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
        end
        else
        begin
            if (step)
                phase <= phase + 2'd1;
            unique case (state)
                TWM_IDLE:
                    // start request goes to bus test
                    if (ctl_sta && !flag)
                        state <= TWM_WAIT_FREE;
                TWM_WAIT_FREE:
                    if (!busy)
                    begin
                        state   <= TWM_START;
                        phase   <= 2'd0;
                        sda_low <= 1'b0;
                    end
                TWM_START:
                    if (step)
                        unique case (phase)
                            2'd0: scl_low <= 1'b0;
                            2'd1: sda_low <= 1'b1;
                            2'd2: scl_low <= 1'b1;
                            2'd3:
                            begin
                                owner <= 1'b1;
                                state <= TWM_HOLD;
                            end
                        endcase
                TWM_BIT:
                    if (lost_now)
                    begin
                        // lose arbitration, let go of both lines
                        state   <= TWM_LOST;
                        owner   <= 1'b0;
                        scl_low <= 1'b0;
                        sda_low <= 1'b0;
                    end
                    else if (step)
                        unique case (phase)
                            2'd0: scl_low <= 1'b0;
                            2'd1:
                                if (bitn < 4'h8)
                                    shreg <= {shreg[6:0], line_now.sda};
                                else
                                    ack_rx <= !line_now.sda;
                            2'd2: scl_low <= 1'b1;
                            2'd3:
                                if (bitn == 4'h8)
                                begin
                                    state   <= TWM_HOLD;
                                    sda_low <= 1'b0;
                                    if (addr_byte)
                                        tx <= !rd_dir;
                                end
                                else
                                begin
                                    bitn    <= bitn + 4'h1;
                                    sda_low <= bit_drive(bitn + 4'h1, tx, shreg[7], ack_sent);
                                end
                        endcase
                TWM_HOLD:
                    if (!flag)
                    begin
                        phase <= 2'd0;
                        bitn  <= 4'h0;
                        if (ctl_sto)
                        begin
                            // stop first, start after if asked
                            state   <= TWM_STOP;
                            sda_low <= 1'b1;
                        end
                        else if (ctl_sta)
                        begin
                            state   <= TWM_START;
                            sda_low <= 1'b0;
                        end
                        else if (code_addr || code_tx)
                        begin
                            state     <= TWM_BIT;
                            tx        <= 1'b1;
                            addr_byte <= code_addr;
                            if (code_addr)
                                rd_dir <= data_reg[0];
                            shreg     <= data_reg;
                            sda_low   <= bit_drive(4'h0, 1'b1, data_reg[7], ctl_ack);
                        end
                        else if (code_rx)
                        begin
                            // receive, answer as acknowledge enable says
                            state     <= TWM_BIT;
                            tx        <= 1'b0;
                            addr_byte <= 1'b0;
                            ack_sent  <= ctl_ack;
                            sda_low   <= 1'b0;
                        end
                    end
                TWM_LOST:
                    // retry start or drop to unaddressed
                    if (!flag)
                        state <= ctl_sta ? TWM_WAIT_FREE : TWM_IDLE;
                TWM_STOP:
                    if (step)
                        unique case (phase)
                            2'd0: scl_low <= 1'b0;
                            2'd1: sda_low <= 1'b0;
                            2'd2: owner   <= 1'b0;
                            2'd3: state   <= ctl_sta ? TWM_WAIT_FREE : TWM_IDLE;
                        endcase
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_dis_idle;
        !ctl_en |=> state == TWM_IDLE && !scl_low && !sda_low;
    endproperty
    a_dis_idle: assert property (p_dis_idle) else $error("bus active while disabled");

    property p_go_start;
        state == TWM_IDLE && ctl_en && ctl_sta && !flag |=> state == TWM_WAIT_FREE;
    endproperty
    a_go_start: assert property (p_go_start) else $error("start request not taken");

    property p_flag_clr;
        wr_ctl && w_byte[`TWM_B_FLAG] && !set_flag |=> !flag;
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

    property p_start_code;
        start_dn && !owner |=> flag && status_code == `TWM_ST_START && state == TWM_HOLD;
    endproperty
    a_start_code: assert property (p_start_code) else $error("start code wrong");

    property p_rstart_code;
        start_dn && owner |=> flag && status_code == `TWM_ST_RSTART;
    endproperty
    a_rstart_code: assert property (p_rstart_code) else $error("repeat code wrong");

    property p_stop_clr;
        stop_dn && !wr_ctl |=> !ctl_sto && !owner && !sda_low;
    endproperty
    a_stop_clr: assert property (p_stop_clr) else $error("stop not ended");

    property p_collide;
        wr_dat && !flag |=> ctl_wc && $stable(data_reg);
    endproperty
    a_collide: assert property (p_collide) else $error("collision missed");

    property p_stretch;
        state == TWM_HOLD |-> scl_low && flag || !flag;
    endproperty
    a_stretch: assert property (p_stretch) else $error("clock not held");

    property p_rx_ack;
        rx_load && ack_sent |=> flag && status_code == `TWM_ST_RD_ACK && data_reg == $past(shreg);
    endproperty
    a_rx_ack: assert property (p_rx_ack) else $error("ack byte status wrong");

    property p_rx_nak;
        rx_load && !ack_sent |=> status_code == `TWM_ST_RD_NAK && data_reg == $past(shreg);
    endproperty
    a_rx_nak: assert property (p_rx_nak) else $error("nack byte status wrong");

endmodule : twm_master_rx

//--- testbench/twm_slave_model.sv
// Purpose: slave transmitter on the two-wire bus
// Assumes: lines are resolved with pull-ups
// Notes:   acks ADDR only, sends tx_byte for every read byte
`timescale 1ns/1ps
module twm_slave_model #(parameter logic [6:0] ADDR = 7'h2a) (
    // bus side
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic [7:0] tx_byte,
    output logic            sda_oe
);
    logic [7:0] sh = 8'h00;
    logic [7:0] tx = 8'h00;
    logic       on = 1'b0;
    logic       rd = 1'b0;
    int         cnt = 0;
    int         b = 0;
    // released until the first frame, so the pulled-up line reads high
    initial sda_oe = 1'b0;
    // start reframes, stop parks the model
    always @(negedge sda)
        if (scl)
        begin
            on = 1'b1;
            rd = 1'b0;
            cnt = -1;
        end
    always @(posedge sda) if (scl) on = 1'b0;
    // a nack from the master ends the read
    always @(posedge scl)
        if (on && cnt < 8) sh = {sh[6:0], sda};
        else if (rd && b == 8 && sda) on = 1'b0;
    // change the drive only on the falling scl edge, hold it while scl is high
    always @(negedge scl)
    begin
        cnt = cnt + 1;
        b = (cnt - 9) % 9;
        if (cnt == 9) rd = (sh[7:1] == ADDR) && sh[0];
        if (rd && b == 0) tx = tx_byte;
        sda_oe = on && ((cnt == 8 && sh[7:1] == ADDR) || (rd && b < 8 && !tx[7 - b]));
    end
endmodule : twm_slave_model

//--- testbench/two_wire_master_receiver_tb_top.sv
// Purpose: self-checking bench of the master receiver
// Assumes: slave model answers 7'h2a
// Notes:   status is compared with the prescaler bits masked
`timescale 1ns/1ps
`include "twm_cfg.svh"
module two_wire_master_receiver_tb_top;
    import twm_pkg::*;
    logic sys_clk = 1'b0, sys_rst = 1'b1, s_oe;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, tx_byte = 8'h00, v, q[$];
    logic [31:0] wdata = 32'h0, rdata, seed = 32'h5d;
    logic [1:0] bresp, rresp;
    logic [23:0] steps [8] = '{24'h00a408, 24'h55c440, 24'h00c450, 24'h008458,
                               24'h00b408, 24'h578448, 24'h00a410, 24'h578448};
    twm_pins_t pins;
    wire scl = !pins.scl_oe;
    wire sda = !(pins.sda_oe || s_oe);
    int fails = 0;
    int samples_checked = 0;
    always #5 sys_clk = !sys_clk;
    twm_master_rx i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(4'h1), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .scl_in(scl), .sda_in(sda), .pins_out(pins));
    twm_slave_model i_slave (.scl(scl), .sda(sda), .tx_byte(tx_byte), .sda_oe(s_oe));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        xorshift = x ^ (x << 5);
    endfunction : xorshift
    task automatic axw(input logic [7:0] a, input logic [7:0] d);
        logic ad = 1'b0, dd = 1'b0;
        @(posedge sys_clk);
        {awaddr, wdata} <= {a, 24'h0, d};
        {awvalid, wvalid, bready} <= 3'h7;
        while (!(ad && dd))
        begin
            @(posedge sys_clk);
            ad |= awready;
            dd |= wready;
            awvalid <= !ad;
            wvalid <= !dd;
        end
        while (!bvalid) @(posedge sys_clk);
        bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge sys_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (!rvalid);
        d = rdata[7:0];
        rready <= 1'b0;
    endtask : axr
    task automatic tally_and_finish();
        if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (90000) @(posedge sys_clk);
        fails++;
        tally_and_finish();
    end
    initial
    begin
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        axr(`TWM_OFF_STAT, v);
        chk("stat_rst", v, `TWM_STAT_RST);
        axr(8'h0c, v);
        chk("unmapped", v, 8'h00);
        chk("rresp", 8'(rresp), 8'(`TWM_RESP_SLV));
        axw(`TWM_OFF_CTRL, 8'ha0);
        chk("bresp", 8'(bresp), 8'(`TWM_RESP_OKAY));
        repeat (1500) @(posedge sys_clk);
        chk("idle_lines", 8'({scl, sda}), 8'h03);
        axw(`TWM_OFF_CTRL, 8'h04);
        axw(`TWM_OFF_DATA, 8'h55);
        axr(`TWM_OFF_CTRL, v);
        chk("collision", v & 8'h88, 8'h08);
        // table of software actions with the status each must give
        foreach (steps[i])
        begin
            seed = xorshift(seed);
            tx_byte <= seed[7:0];
            // the slave latches its next byte as an acked address or byte ends
            if (steps[i][7:0] == 8'h40 || steps[i][7:0] == 8'h50) q.push_back(seed[7:0]);
            // load the read address before the flag clear, ack off for the last byte
            if (steps[i][23:16] != 8'h00) axw(`TWM_OFF_DATA, steps[i][23:16]);
            axw(`TWM_OFF_CTRL, steps[i][15:8]);
            do axr(`TWM_OFF_CTRL, v); while (v[7] !== 1'b1);
            chk("stop_bit", v & 8'h10, 8'h00);
            axr(`TWM_OFF_STAT, v);
            chk("status", v & 8'hf8, steps[i][7:0]);
            axr(`TWM_OFF_DATA, v);
            if (steps[i][7:0] >= 8'h50) chk("rx_byte", v, q.pop_front());
        end
        chk("scl_held", 8'(scl), 8'h00);
        axw(`TWM_OFF_CTRL, 8'h94);
        repeat (1500) @(posedge sys_clk);
        axr(`TWM_OFF_CTRL, v);
        chk("after_stop", v & 8'h90, 8'h00);
        chk("stop_lines", 8'({scl, sda}), 8'h03);
        tally_and_finish();
    end
endmodule : two_wire_master_receiver_tb_top
